/* uepc_cmd_port.sv */
// Purpose: command port of a USB device controller: buffers, status, DMA counter
// Assumes: bus strobes are one-cycle pulses from logic on the same clock
// Notes: one word per data phase; serial engine supplies buffer flags
//
// Behaviour
// - Counter write loads; read gives remaining bytes
// - Bus reset keeps counter; hardware reset zeroes
// - Enabling DMA reloads working counter
// - Soft reset command clears like hardware reset, but keeps the read data, DMA output, end_of_transfer and send registers
// - Buffer write and read code ranges
// - Pointer restarts; at most M+1 words
// - Pointer advances one word per access
// - Word 0 length, payload from word 1
// - DMA skips header; flags last word
// - Writer fills buffer; END_OF_TRANSFER sends partial
// - Buffer size limited per endpoint type; here one BUF_BYTES size serves every endpoint
// - DMA rolls into secondary buffer
// - Select high command low byte; low data
// - Status read codes, one byte each
// - Status read clears endpoint pending flag
// - Bits 6,5 buffers full; 2 setup
// - Bit 4 toggle; bit 1 CPU buffer
// - Setup_clobbered bit set; read clears after storing
// - Count end raises END_OF_TRANSFER at zero
// - Run bit starts, stops, bus reset clears
`timescale 1ns/1ps
module uepc_cmd_port #(
  parameter int BUF_BYTES = uepc_pkg::BUF_BYTES_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Processor bus
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic command_data_select,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_rvalid,
  // DMA side
  input wire logic dma_strobe,
  input wire logic dma_to_buffer,
  input wire logic [15:0] dma_wdata,
  input wire logic ext_eot,
  input wire logic [uepc_pkg::EP_NUM-1:0] ep_double_buf,
  output logic [15:0] dma_rdata,
  output logic dma_valid,
  output logic dma_eop,
  output logic end_of_transfer,
  output logic buffer_send_now,
  output logic dma_running,
  // Serial engine
  input wire logic usb_bus_reset,
  input wire logic setup_token,
  input wire logic setup_clobber,
  input wire logic [3:0] setup_ep,
  input wire logic setup_store_busy,
  input wire logic [uepc_pkg::EP_NUM-1:0] primary_buffer_full,
  input wire logic [uepc_pkg::EP_NUM-1:0] secondary_buffer_full,
  input wire logic [uepc_pkg::EP_NUM-1:0] next_toggle_bit,
  input wire logic [uepc_pkg::EP_NUM-1:0] setup_packet_present,
  input wire logic [uepc_pkg::EP_NUM-1:0] cpu_buffer_select,
  input wire logic sie_we,
  input wire logic [3:0] sie_ep,
  input wire logic sie_half,
  input wire logic [15:0] sie_word,
  input wire logic [15:0] sie_wdata,
  // Interrupt and halt flags
  input wire logic [uepc_pkg::EP_NUM-1:0] ep_event,
  output logic [uepc_pkg::EP_NUM-1:0] interrupt_flag_register,
  output logic [uepc_pkg::EP_NUM-1:0] endpoint_halted
);
  import uepc_pkg::*;

  localparam int DEPTH = (BUF_BYTES + 1) / 2 + 1;
  localparam int PW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(EP_NUM * 2 * DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [PW-1:0] FIRST = PW'(HDR_WORDS);

  function automatic logic [AW-1:0] widx(input logic [3:0] ep, input logic half, input logic [PW-1:0] w);
    widx = AW'(int'({ep, half}) * DEPTH + int'(w));
  endfunction

  logic [15:0] mem [EP_NUM*2*DEPTH];
  uepc_cls_t cls_q, cls_d;
  logic [3:0] ep_q;
  logic [PW-1:0] ptr_q, dptr_q;
  logic dhalf_q, srst_q;
  logic [15:0] prog_q, work_q;
  logic run_q, cnt_end_q;
  logic [3:0] dep_q;
  logic [EP_NUM-1:0] halt_q, clob_q, irq_q;
  logic [15:0] rdata_q, drdata_q;
  logic rvalid_q, dvalid_q, deop_q, eot_q, send_q;

  // Command decode; the upper byte is ignored in the command phase
  wire cmd_wr = bus_wr & command_data_select;
  wire dat_wr = bus_wr & ~command_data_select;
  wire dat_rd = bus_rd & ~command_data_select;
  wire [7:0] code = bus_wdata[7:0];
  wire [3:0] nib = code[3:0];
  wire is_bwr = code >= CMD_BWR_LO && code <= CMD_BWR_HI;
  wire is_brd = code == CMD_BRD_CTRL || (code >= CMD_BRD_LO && code <= CMD_BRD_HI);
  wire is_stat = code[7:4] == GRP_STATUS;
  wire is_stall = cmd_wr && code[7:4] == GRP_STALL;
  wire is_unstall = cmd_wr && code[7:4] == GRP_UNSTALL;
  wire soft_rst = cmd_wr && code == CMD_SOFT_RST;
  wire cfg_wr = dat_wr && cls_q == C_CFG;
  wire cnt_wr = dat_wr && cls_q == C_CNT;
  wire stat_rd = dat_rd && cls_q == C_STAT;
  wire in_buf = ptr_q < PW'(DEPTH);
  wire buf_wr = dat_wr && cls_q == C_BWR && in_buf;
  wire buf_rd = dat_rd && cls_q == C_BRD && in_buf;
  wire cpu_half = cpu_buffer_select[ep_q];
  wire [AW-1:0] cpu_idx = widx(ep_q, cpu_half, ptr_q);

  // DMA datapath
  wire run_set = cfg_wr && bus_wdata[CFG_RUN_POS] && !run_q;
  wire dma_go = dma_strobe && run_q && work_q != CNT_RST;
  wire dma_last = work_q <= BYTES_PER_WORD;
  wire dbuf_end = dptr_q == LAST;
  wire roll = dbuf_end && ep_double_buf[dep_q] && !dhalf_q;
  wire count_eot = dma_go && dma_last && cnt_end_q;
  wire [AW-1:0] dma_idx = widx(dep_q, dhalf_q, dptr_q);
  wire [7:0] stat_byte = {halt_q[ep_q], secondary_buffer_full[ep_q], primary_buffer_full[ep_q],
                          next_toggle_bit[ep_q], clob_q[ep_q], setup_packet_present[ep_q],
                          cpu_half, 1'b0};
  wire [15:0] cfg_word = 16'({cnt_end_q, 11'h000, run_q, 3'h0} | (16'(dep_q) << CFG_EP_LSB));

  always_comb begin
    cls_d = cls_q;
    if (cmd_wr) begin
      if (is_bwr) cls_d = C_BWR;
      else if (is_brd) cls_d = C_BRD;
      else if (is_stat) cls_d = C_STAT;
      else if (code == CMD_CNT_WR || code == CMD_CNT_RD) cls_d = C_CNT;
      else if (code == CMD_CFG_WR || code == CMD_CFG_RD) cls_d = C_CFG;
      else cls_d = C_NONE;
    end
  end

  // Soft reset is applied one cycle after the command, unlike the asynchronous reset pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) srst_q <= 1'b0;
    else srst_q <= soft_rst && !srst_q;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cls_q <= C_NONE;
      ep_q <= 4'h0;
      ptr_q <= '0;
    end else if (srst_q) begin
      cls_q <= C_NONE;
      ep_q <= 4'h0;
      ptr_q <= '0;
    end else begin
      cls_q <= cls_d;
      if (cmd_wr) begin
        ep_q <= nib;
        ptr_q <= '0;
      end else if (buf_wr || buf_rd) begin
        ptr_q <= ptr_q + PW'(1);
      end
    end
  end

  // Counter: bus reset leaves the programmed value alone
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prog_q <= CNT_RST;
      work_q <= CNT_RST;
      run_q <= 1'b0;
      cnt_end_q <= 1'b0;
      dep_q <= 4'h0;
      dptr_q <= '0;
      dhalf_q <= 1'b0;
    end else if (srst_q) begin
      prog_q <= CNT_RST;
      work_q <= CNT_RST;
      run_q <= 1'b0;
      cnt_end_q <= 1'b0;
      dep_q <= 4'h0;
      dptr_q <= '0;
      dhalf_q <= 1'b0;
    end else begin
      if (cnt_wr) prog_q <= bus_wdata;
      if (cfg_wr) begin
        cnt_end_q <= bus_wdata[CFG_CNT_END_POS];
        dep_q <= bus_wdata[CFG_EP_LSB+:4];
      end
      if (usb_bus_reset || ext_eot || count_eot) run_q <= 1'b0;
      else if (cfg_wr) run_q <= bus_wdata[CFG_RUN_POS];
      if (run_set) begin
        work_q <= prog_q;
        dptr_q <= FIRST;
        dhalf_q <= 1'b0;
      end else if (dma_go) begin
        work_q <= dma_last ? CNT_RST : work_q - BYTES_PER_WORD;
        if (roll) begin
          dhalf_q <= 1'b1;
          dptr_q <= FIRST;
        end else if (!dbuf_end) begin
          dptr_q <= dptr_q + PW'(1);
        end
      end
    end
  end

  // Flags: a hardware set in the same cycle as a clear wins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      halt_q <= FLAGS_RST;
      clob_q <= FLAGS_RST;
      irq_q <= FLAGS_RST;
    end else if (srst_q) begin
      halt_q <= FLAGS_RST;
      clob_q <= FLAGS_RST;
      irq_q <= FLAGS_RST;
    end else begin
      for (int i = 0; i < EP_NUM; i++) begin
        if (is_stall && nib == 4'(i)) halt_q[i] <= 1'b1;
        else if ((is_unstall && nib == 4'(i)) || (setup_token && setup_ep == 4'(i))) halt_q[i] <= 1'b0;
        if (setup_clobber && setup_ep == 4'(i)) clob_q[i] <= 1'b1;
        else if (stat_rd && ep_q == 4'(i) && !setup_store_busy) clob_q[i] <= 1'b0;
        if (ep_event[i]) irq_q[i] <= 1'b1;
        else if (stat_rd && ep_q == 4'(i)) irq_q[i] <= 1'b0;
      end
    end
  end

  // Buffer memory; the bus, DMA and serial engine never write together by use
  always_ff @(posedge clock) begin
    if (buf_wr) mem[cpu_idx] <= bus_wdata;
    else if (dma_go && dma_to_buffer) mem[dma_idx] <= dma_wdata;
    else if (sie_we) mem[widx(sie_ep, sie_half, sie_word[PW-1:0])] <= sie_wdata;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      drdata_q <= 16'h0000;
      dvalid_q <= 1'b0;
      deop_q <= 1'b0;
      eot_q <= 1'b0;
      send_q <= 1'b0;
    end else begin
      rvalid_q <= dat_rd && !srst_q;
      if (buf_rd) rdata_q <= mem[cpu_idx];
      else if (stat_rd) rdata_q <= {STAT_RST, stat_byte};
      else if (dat_rd && cls_q == C_CNT) rdata_q <= work_q;
      else if (dat_rd && cls_q == C_CFG) rdata_q <= cfg_word;
      else if (dat_rd) rdata_q <= 16'h0000;
      dvalid_q <= dma_go && !dma_to_buffer;
      if (dma_go && !dma_to_buffer) begin
        drdata_q <= mem[dma_idx];
        deop_q <= dma_last || (dbuf_end && !roll);
      end
      eot_q <= count_eot;
      send_q <= ext_eot && run_q;
    end
  end

  assign bus_rdata = rdata_q;
  assign bus_rvalid = rvalid_q;
  assign dma_rdata = drdata_q;
  assign dma_valid = dvalid_q;
  assign dma_eop = deop_q;
  assign end_of_transfer = eot_q;
  assign buffer_send_now = send_q;
  assign dma_running = run_q;
  assign interrupt_flag_register = irq_q;
  assign endpoint_halted = halt_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_reload;
    run_set && !srst_q |=> work_q == $past(prog_q) && dptr_q == FIRST && run_q;
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded");

  property p_soft;
    soft_rst && !srst_q |=> ##1 prog_q == CNT_RST && !run_q && irq_q == FLAGS_RST && cls_q == C_NONE;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset incomplete");

  property p_busrst;
    usb_bus_reset && !cnt_wr && !srst_q |=> prog_q == $past(prog_q) && !run_q;
  endproperty
  a_busrst: assert property (p_busrst) else $error("bus reset wrong");

  property p_ptr_start;
    cmd_wr && (is_bwr || is_brd) && !srst_q |=> ptr_q == '0 ##1 ptr_q <= PW'(1);
  endproperty
  a_ptr_start: assert property (p_ptr_start) else $error("pointer not restarted");

  property p_ptr_adv;
    (buf_wr || buf_rd) && !srst_q |=> ptr_q == $past(ptr_q) + PW'(1);
  endproperty
  a_ptr_adv: assert property (p_ptr_adv) else $error("pointer not advanced");

  property p_cap;
    ptr_q <= PW'(DEPTH);
  endproperty
  a_cap: assert property (p_cap) else $error("pointer past buffer");

  property p_stat_clr;
    stat_rd && !ep_event[ep_q] && !srst_q |=> !irq_q[$past(ep_q)] && bus_rvalid;
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("pending flag kept");

  property p_eot;
    count_eot && !srst_q |=> end_of_transfer && !run_q && work_q == CNT_RST;
  endproperty
  a_eot: assert property (p_eot) else $error("no end of transfer");

  property p_roll;
    dma_go && roll && !run_set && !srst_q |=> dhalf_q && dptr_q == FIRST;
  endproperty
  a_roll: assert property (p_roll) else $error("no secondary rollover");

  property p_stall;
    is_stall && !srst_q |=> endpoint_halted[$past(nib)];
  endproperty
  a_stall: assert property (p_stall) else $error("stall not set");

  c_buf_fill: cover property (buf_wr ##1 buf_wr ##1 buf_wr);
  c_dma_eot: cover property (run_set ##[1:40] count_eot);
  c_roll: cover property (dma_go && roll);
  c_clob_rd: cover property (stat_rd && clob_q[ep_q] && !setup_store_busy);
endmodule

/* uepc_pkg.sv */
// Purpose: constants of the endpoint command port
// Assumes: 16-bit processor bus, command codes on the low byte
// Notes: codes, field positions and reset values live here; the status byte and config readback repeat the positions inline
package uepc_pkg;
  // Command codes
  localparam logic [7:0] CMD_BWR_LO = 8'h01;
  localparam logic [7:0] CMD_BWR_HI = 8'h0f;
  localparam logic [7:0] CMD_BRD_CTRL = 8'h10;
  localparam logic [7:0] CMD_BRD_LO = 8'h12;
  localparam logic [7:0] CMD_BRD_HI = 8'h1f;
  localparam logic [3:0] GRP_STALL = 4'h4;
  localparam logic [3:0] GRP_STATUS = 4'h5;
  localparam logic [3:0] GRP_UNSTALL = 4'h8;
  localparam logic [7:0] CMD_CFG_WR = 8'hf0;
  localparam logic [7:0] CMD_CFG_RD = 8'hf1;
  localparam logic [7:0] CMD_CNT_WR = 8'hf2;
  localparam logic [7:0] CMD_CNT_RD = 8'hf3;
  localparam logic [7:0] CMD_SOFT_RST = 8'hf6;
  // DMA configuration fields
  localparam int CFG_CNT_END_POS = 15;
  localparam int CFG_EP_LSB = 4;
  localparam int CFG_RUN_POS = 3;
  // Endpoint state byte fields
  localparam int ST_HALT = 7;
  localparam int ST_FULL1 = 6;
  localparam int ST_FULL0 = 5;
  localparam int ST_TOGGLE = 4;
  localparam int ST_CLOB = 3;
  localparam int ST_SETUP = 2;
  localparam int ST_CPU_BUFFER_SELECT = 1;
  // Reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  // Buffer layout
  localparam int EP_NUM = 16;
  localparam int BUF_BYTES_DEF = 32;
  localparam int HDR_WORDS = 1;
  localparam logic [15:0] BYTES_PER_WORD = 16'h0002;
  // Command class after the last command phase
  typedef enum logic [5:0] {
    C_NONE = 6'b000001,
    C_BWR = 6'b000010,
    C_BRD = 6'b000100,
    C_STAT = 6'b001000,
    C_CNT = 6'b010000,
    C_CFG = 6'b100000
  } uepc_cls_t;
endpackage

/* uepc_host_model.sv */
// Purpose: processor model that drives the command port bus
// Assumes: one strobe pulse per access, driven just after a rising edge
// Notes: idle data lines show the inverse of the last word, never a stale copy
`timescale 1ns/1ps
module uepc_host_model (
  // Clock
  input wire logic clock,
  // Processor bus
  output logic bus_wr,
  output logic bus_rd,
  output logic command_data_select,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_rvalid
);
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    command_data_select = 1'b1;
    bus_wdata = 16'h0000;
  end
  // Command or data write; caller keeps direction per command
  task automatic put(input logic sel, input logic [15:0] w);
    @(posedge clock);
    bus_wr <= 1'b1;
    command_data_select <= sel;
    bus_wdata <= w;
    @(posedge clock);
    bus_wr <= 1'b0;
    bus_wdata <= ~w;
  endtask
  // Data read; the answer stands one cycle, so it is taken at the next edge
  task automatic get(output logic [15:0] r, output logic ok);
    @(posedge clock);
    bus_rd <= 1'b1;
    command_data_select <= 1'b0;
    @(posedge clock);
    bus_rd <= 1'b0;
    @(posedge clock);
    ok = bus_rvalid;
    r = bus_rdata;
  endtask
endmodule

/* tb_usb_device_endpoint_command_port.sv */
// Purpose: self-checking bench of the endpoint command port
// Assumes: default buffer size, processor model drives the bus
// Notes: serial engine memory port is left idle; DMA writes only in the rollover test
`timescale 1ns/1ps
module tb_usb_device_endpoint_command_port;
  import uepc_pkg::*;
  localparam int DEPTH = (BUF_BYTES_DEF + 1) / 2 + 1;
  logic clock, arst_n, bus_wr, bus_rd, command_data_select, bus_rvalid, ok;
  logic dma_strobe, dma_to_buffer, ext_eot, dma_valid, dma_eop, end_of_transfer, buffer_send_now;
  logic dma_running, usb_bus_reset, setup_token, setup_clobber, setup_store_busy, sie_we, sie_half;
  logic [15:0] bus_wdata, bus_rdata, dma_wdata, dma_rdata, sie_word, sie_wdata, rv;
  logic [3:0] setup_ep, sie_ep;
  logic [EP_NUM-1:0] ep_double_buf, primary_buffer_full, secondary_buffer_full, next_toggle_bit;
  logic [EP_NUM-1:0] setup_packet_present, cpu_buffer_select, ep_event, interrupt_flag_register, endpoint_halted;
  int err_count, samples_checked;
  // Size kept at the bulk limit
  uepc_cmd_port #(.BUF_BYTES(BUF_BYTES_DEF)) i_uepc_cmd_port (.clock, .arst_n, .bus_wr, .bus_rd,
    .command_data_select, .bus_wdata, .bus_rdata, .bus_rvalid, .dma_strobe, .dma_to_buffer, .dma_wdata,
    .ext_eot, .ep_double_buf, .dma_rdata, .dma_valid, .dma_eop, .end_of_transfer, .buffer_send_now,
    .dma_running, .usb_bus_reset, .setup_token, .setup_clobber, .setup_ep, .setup_store_busy,
    .primary_buffer_full, .secondary_buffer_full, .next_toggle_bit, .setup_packet_present,
    .cpu_buffer_select, .sie_we, .sie_ep, .sie_half, .sie_word, .sie_wdata, .ep_event,
    .interrupt_flag_register, .endpoint_halted);
  uepc_host_model i_uepc_host_model (.clock, .bus_wr, .bus_rd, .command_data_select, .bus_wdata,
    .bus_rdata, .bus_rvalid);
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Upper byte of a command is junk on purpose
  task automatic cmd(input logic [7:0] c);
    i_uepc_host_model.put(1'b1, {8'h5a, c});
  endtask
  task automatic dw(input logic [15:0] w);
    i_uepc_host_model.put(1'b0, w);
  endtask
  task automatic dr(input string n, input logic [15:0] e);
    i_uepc_host_model.get(rv, ok);
    chk({n, " valid"}, 16'h0001, {15'h0, ok});
    chk(n, e, rv);
  endtask
  task automatic t_counter();
    cmd(CMD_CNT_RD);
    dr("count at reset", CNT_RST);
    cmd(CMD_CNT_WR);
    dw(16'h1234);
    cmd(CMD_CFG_WR);
    dw(16'h0038);
    cmd(CMD_CNT_RD);
    dr("count reloaded", 16'h1234);
    @(posedge clock);
    usb_bus_reset <= 1'b1;
    @(posedge clock);
    usb_bus_reset <= 1'b0;
    @(posedge clock);
    chk("run after bus reset", 16'h0000, {15'h0, dma_running});
    cmd(CMD_CFG_WR);
    dw(16'h0038);
    cmd(CMD_CNT_RD);
    dr("count kept by bus reset", 16'h1234);
    cmd(CMD_SOFT_RST);
    repeat (3) @(posedge clock);
    chk("run after soft reset", 16'h0000, {15'h0, dma_running});
    cmd(CMD_CNT_RD);
    dr("count after soft reset", CNT_RST);
    $display("t_counter done");
  endtask
  task automatic t_buffer();
    cmd(CMD_BWR_LO);
    for (int i = 2; i <= 15; i++) begin
      cmd(8'(i));
      for (int k = 0; k <= DEPTH; k++) dw({8'(i), 8'(k)});
      cmd(CMD_BRD_CTRL | 8'(i));
      for (int k = 0; k < DEPTH; k++) dr("buffer word", {8'(i), 8'(k)});
    end
    cmd(8'h13);
    dr("pointer restart", 16'h0300);
    $display("t_buffer done");
  endtask
  task automatic t_dma();
    cmd(CMD_CNT_WR);
    dw(16'h0004);
    cmd(CMD_CFG_WR);
    dw(16'h8038);
    @(posedge clock);
    chk("run on", 16'h0001, {15'h0, dma_running});
    cmd(CMD_CFG_RD);
    dr("config readback", 16'h8038);
    for (int k = 1; k <= 3; k++) begin
      @(posedge clock);
      dma_strobe <= 1'b1;
      @(posedge clock);
      dma_strobe <= 1'b0;
      @(posedge clock);
      chk("dma valid", {15'h0, k < 3}, {15'h0, dma_valid});
      if (k < 3) chk("dma word", 16'h0300 | 16'(k), dma_rdata);
      if (k < 3) chk("dma eop", {15'h0, k == 2}, {15'h0, dma_eop});
      chk("count end", {15'h0, k == 2}, {15'h0, end_of_transfer});
    end
    cmd(CMD_CNT_RD);
    dr("count remaining", 16'h0000);
    cmd(CMD_CNT_WR);
    dw(16'h0008);
    cmd(CMD_CFG_WR);
    dw(16'h0038);
    cmd(CMD_CNT_RD);
    dr("count second run", 16'h0008);
    @(posedge clock);
    ext_eot <= 1'b1;
    @(posedge clock);
    ext_eot <= 1'b0;
    @(posedge clock);
    chk("send partial", 16'h0001, {15'h0, buffer_send_now});
    chk("run after eot", 16'h0000, {15'h0, dma_running});
    $display("t_dma done");
  endtask
  // Double-buffered endpoint 2 filled by DMA past the primary half
  task automatic t_dma_roll();
    ep_double_buf <= 16'h0004;
    dma_to_buffer <= 1'b1;
    cmd(CMD_CNT_WR);
    dw(16'h0022);
    cmd(CMD_CFG_WR);
    dw(16'h8028);
    for (int k = 1; k <= 17; k++) begin
      @(posedge clock);
      dma_strobe <= 1'b1;
      dma_wdata <= 16'ha000 | 16'(k);
      @(posedge clock);
      dma_strobe <= 1'b0;
    end
    @(posedge clock);
    chk("write count end", 16'h0001, {15'h0, end_of_transfer});
    chk("run after write", 16'h0000, {15'h0, dma_running});
    dma_to_buffer <= 1'b0;
    cmd(8'h12);
    for (int k = 0; k < DEPTH; k++) dr("dma written word", k == 0 ? 16'h0200 : 16'ha000 | 16'(k));
    cpu_buffer_select <= 16'h0004;
    cmd(8'h12);
    i_uepc_host_model.get(rv, ok);
    dr("dma rollover word", 16'ha011);
    cpu_buffer_select <= 16'h0000;
    $display("t_dma_roll done");
  endtask
  task automatic t_status();
    cmd(8'h43);
    @(posedge clock);
    chk("halted", 16'h0001, {15'h0, endpoint_halted[3]});
    ep_event <= 16'h0008;
    @(posedge clock);
    ep_event <= 16'h0000;
    @(posedge clock);
    chk("flag set", 16'h0001, {15'h0, interrupt_flag_register[3]});
    cmd(8'h53);
    dr("status stalled", 16'h0080);
    chk("flag cleared", 16'h0000, {15'h0, interrupt_flag_register[3]});
    cmd(8'h83);
    @(posedge clock);
    chk("unstalled", 16'h0000, {15'h0, endpoint_halted[3]});
    cmd(8'h43);
    setup_token <= 1'b1;
    setup_clobber <= 1'b1;
    setup_ep <= 4'h3;
    setup_store_busy <= 1'b1;
    primary_buffer_full <= 16'h0008;
    secondary_buffer_full <= 16'h0008;
    next_toggle_bit <= 16'h0008;
    setup_packet_present <= 16'h0008;
    cpu_buffer_select <= 16'h0008;
    @(posedge clock);
    setup_token <= 1'b0;
    setup_clobber <= 1'b0;
    cmd(8'h53);
    dr("status while storing", 16'h007e);
    setup_store_busy <= 1'b0;
    cmd(8'h53);
    dr("status stored", 16'h007e);
    cmd(8'h53);
    dr("status setup_clobbered cleared", 16'h0076);
    $display("t_status done");
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    err_count = 0;
    samples_checked = 0;
    {arst_n, dma_strobe, dma_to_buffer, ext_eot, usb_bus_reset, setup_token, setup_clobber} = '0;
    {setup_store_busy, sie_we, sie_half, setup_ep, sie_ep, dma_wdata, sie_word, sie_wdata} = '0;
    {ep_double_buf, primary_buffer_full, secondary_buffer_full, next_toggle_bit} = '0;
    {setup_packet_present, cpu_buffer_select, ep_event} = '0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    t_counter();
    t_buffer();
    t_dma();
    t_dma_roll();
    t_status();
    conclude();
  end
  initial begin
    #60000;
    err_count++;
    conclude();
  end
endmodule
